// ===== logic/cb_pm_defs.svh
// Notes on behaviour
// - in D2 card clock stays stopped unless the card asks for it via clock run.
// - without working clock run, card clock is off and card bus idle through D2.
// - no card functional or card status-change interrupts are delivered in D2.
// - power event output fires in D2 and D3hot only with the enable bit set.
// - card removal is still detected in D2 and D3hot.
// - socket supply is held in D2 and D3hot, except it may drop on card removal.
// - in D2 primary clock is stopped unless clock run is needed; primary bus idle.
// - no primary bus interrupts, of any style, while in D2.
// - D2 keeps all context and config space; functional context is not reachable.
// - in D2 and D3hot only type 0 config cycles to this device are claimed.
// - in D3hot the card clock is fully off whatever clock run asks.
// - in D3hot the card bus floats but card reset and card clock are driven low.
// - no interrupts on either bus in D3hot; primary clock and bus count as off.
// - D3hot keeps config readable and only power event context, while enabled.
// - in D3hot only state field, event enable and event status stay writable.
`ifndef CB_PM_DEFS_SVH
`define CB_PM_DEFS_SVH
`define PM_CSR_OFS      8'h00
`define PM_CTRL_OFS     8'h04
`define PM_STAT_OFS     8'h08
`define PM_IRQ_STAT_OFS 8'h0C
`define PM_IRQ_MASK_OFS 8'h10
`define PM_FUNC_OFS     8'h14
`define CSR_STATE_LSB   0
`define CSR_EN_BIT      8
`define CSR_STS_BIT     15
`define CTRL_CLKRUN_BIT 0
`define CTRL_VCC_BIT    1
`define CTRL_BUSEN_BIT  2
`define IRQ_REMOVE_BIT  0
`define IRQ_INSERT_BIT  1
`define IRQ_CARD_BIT    2
`define IRQ_STSCHG_BIT  3
`define IRQ_PCLK_BIT    4
`define IRQ_W           5
`define CTRL_RST        3'h0
`define FUNC_RST        32'h0000_0000
`define CARD_CLK_DIV    4
`define PCLK_LOSS_NS    2000
`define SYS_PERIOD_NS   25
`define PCLK_LOSS_CYC   ((`PCLK_LOSS_NS + `SYS_PERIOD_NS - 1) / `SYS_PERIOD_NS)
`endif

// ===== logic/cb_pm_pkg.sv
`default_nettype none
package cb_pm_pkg;
  typedef enum logic [1:0]
  {
    PM_D0 = 2'b00,
    PM_D1 = 2'b01,
    PM_D2 = 2'b10,
    PM_D3 = 2'b11
  } pm_state_e;
endpackage : cb_pm_pkg
`default_nettype wire

// ===== logic/cardbus_pm_seq.sv
`include "cb_pm_defs.svh"
`default_nettype none
module cardbus_pm_seq
  import cb_pm_pkg::*;
#(
  parameter int CLK_DIV  = `CARD_CLK_DIV,
  parameter int LOSS_CYC = `PCLK_LOSS_CYC
)
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        srst,
  // register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdata,
  // primary bus
  input  wire logic        pciClk,
  input  wire logic        pciRst_n,
  input  wire logic        cycValid,
  input  wire logic        cycCfg0Self,
  output logic             cycClaim,
  output logic             pciClkStopOk,
  output logic             pciBusIdle,
  output logic             pciInt,
  output logic             pciIntOe_n,
  output logic             pmeOut,
  output logic             pmeOe_n,
  // card side
  input  wire logic        cardDetect_n,
  input  wire logic        cardClkRun,
  input  wire logic        cardIrq_n,
  input  wire logic        cardStsChg_n,
  output logic             cardClk,
  output logic             cardRst_n,
  output logic             cardBusOe_n,
  output logic             slotVccOn,
  // interrupt
  output logic             irq
);

  localparam int NSYNC = 6;
  localparam int SY_PCLK = 0;
  localparam int SY_PRST = 1;
  localparam int SY_CD   = 2;
  localparam int SY_RUN  = 3;
  localparam int SY_CIRQ = 4;
  localparam int SY_CSC  = 5;
  localparam int LW = $clog2(LOSS_CYC + 1);
  localparam int DW = $clog2(CLK_DIV + 1);

  if (CLK_DIV < 2 || (CLK_DIV % 2) != 0 || LOSS_CYC < 2)
  begin : g_bad_param
    $error("CLK_DIV must be even and at least 2, LOSS_CYC at least 2");
  end

  function automatic logic isLow(input pm_state_e s);
    isLow = (s == PM_D2) || (s == PM_D3);
  endfunction : isLow

  function automatic logic legalMove(input pm_state_e from, input pm_state_e to);
    case (from)
      PM_D0:   legalMove = 1'b1;
      PM_D1:   legalMove = 1'b1;
      PM_D2:   legalMove = (to == PM_D0) || (to == PM_D2) || (to == PM_D3);
      PM_D3:   legalMove = (to == PM_D0) || (to == PM_D3);
      default: legalMove = 1'b0;
    endcase
  endfunction : legalMove

  // pin synchronisers: a change counts once stages two and three agree
  logic [NSYNC-1:0] pinRaw;
  logic [NSYNC-1:0] pinS1;
  logic [NSYNC-1:0] pinS2;
  logic [NSYNC-1:0] pinS3;
  logic [NSYNC-1:0] pinF;
  logic [NSYNC-1:0] pinFd;

  assign pinRaw = {cardStsChg_n, cardIrq_n, cardClkRun, cardDetect_n, pciRst_n, pciClk};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++)
    begin : g_sync
      always_ff @(posedge clk_sys)
      begin
        if (srst)
        begin
          pinS1[gi] <= 1'b1;
          pinS2[gi] <= 1'b1;
          pinS3[gi] <= 1'b1;
          pinF[gi]  <= 1'b1;
          pinFd[gi] <= 1'b1;
        end
        else
        begin
          pinS1[gi] <= pinRaw[gi];
          pinS2[gi] <= pinS1[gi];
          pinS3[gi] <= pinS2[gi];
          if (pinS2[gi] == pinS3[gi])
            pinF[gi] <= pinS3[gi];
          pinFd[gi] <= pinF[gi];
        end
      end
    end
  endgenerate

  logic pciRstAct;
  logic cardPresent;
  logic cardRemoved;
  logic cardInserted;
  logic cardIrqEdge;
  logic cardStsEdge;
  logic pclkEdge;

  assign pciRstAct    = ~pinF[SY_PRST];
  assign cardPresent  = ~pinF[SY_CD];
  assign cardRemoved  = pinF[SY_CD] & ~pinFd[SY_CD];
  assign cardInserted = ~pinF[SY_CD] & pinFd[SY_CD];
  assign cardIrqEdge  = ~pinF[SY_CIRQ] & pinFd[SY_CIRQ];
  assign cardStsEdge  = ~pinF[SY_CSC] & pinFd[SY_CSC];
  assign pclkEdge     = pinF[SY_PCLK] & ~pinFd[SY_PCLK];

  // register port decode
  logic csrWr;
  logic ctrlWr;
  logic maskWr;
  logic funcWr;
  logic irqStatRd;

  assign csrWr     = regWr && (regAddr == `PM_CSR_OFS);
  assign ctrlWr    = regWr && (regAddr == `PM_CTRL_OFS);
  assign maskWr    = regWr && (regAddr == `PM_IRQ_MASK_OFS);
  assign funcWr    = regWr && (regAddr == `PM_FUNC_OFS);
  assign irqStatRd = regRd && (regAddr == `PM_IRQ_STAT_OFS);

  // power state
  pm_state_e pmState;
  pm_state_e reqState;

  assign reqState = pm_state_e'(regWdata[`CSR_STATE_LSB +: 2]);

  always_ff @(posedge clk_sys)
  begin
    if (srst || pciRstAct)
      pmState <= PM_D0;
    else if (csrWr && legalMove(pmState, reqState))
      pmState <= reqState;
  end

  logic leaveD3;
  assign leaveD3 = csrWr && (pmState == PM_D3) && (reqState == PM_D0);

  // power event context
  logic pmeEn;
  logic pmeSts;
  logic pmeEvent;

  // card events keep feeding the event even when card interrupts are held off
  assign pmeEvent = cardRemoved | cardInserted | cardStsEdge;

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      pmeEn <= 1'b0;
    else if (csrWr)
      pmeEn <= regWdata[`CSR_EN_BIT];
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      pmeSts <= 1'b0;
    else if (pmeEvent)
      pmeSts <= 1'b1;
    else if (pmState == PM_D3 && !pmeEn)
      pmeSts <= 1'b0;
    else if (csrWr && regWdata[`CSR_STS_BIT])
      pmeSts <= 1'b0;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      pmeOut  <= 1'b0;
      pmeOe_n <= 1'b1;
    end
    else
    begin
      pmeOut  <= 1'b0;
      pmeOe_n <= ~(pmeSts & pmeEn);
    end
  end

  // control and functional context; cleared when leaving D3hot
  logic [2:0]  ctrl;
  logic [31:0] funcCtx;
  logic        ctrlOk;

  // only the csr stays writable in D3hot; functional context closed in D2 too
  assign ctrlOk = (pmState != PM_D3);

  always_ff @(posedge clk_sys)
  begin
    if (srst || pciRstAct || leaveD3)
      ctrl <= `CTRL_RST;
    else if (ctrlWr && ctrlOk)
      ctrl <= regWdata[2:0];
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst || pciRstAct || leaveD3)
      funcCtx <= `FUNC_RST;
    else if (funcWr && !isLow(pmState))
      funcCtx <= regWdata;
  end

  // socket supply: may change only in D0/D1, dropped on removal
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      slotVccOn <= 1'b0;
    else if (cardRemoved || !cardPresent)
      slotVccOn <= 1'b0;
    else if (!isLow(pmState))
      slotVccOn <= ctrl[`CTRL_VCC_BIT];
  end

  // card clock divider, gated by state and clock run
  logic          cardClkEn;
  logic [DW-1:0] divCnt;

  always_comb
  begin
    case (pmState)
      PM_D0:   cardClkEn = 1'b1;
      PM_D1:   cardClkEn = 1'b1;
      PM_D2:   cardClkEn = ctrl[`CTRL_CLKRUN_BIT] && !pinF[SY_RUN];
      PM_D3:   cardClkEn = 1'b0;
      default: cardClkEn = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst || !cardClkEn)
    begin
      divCnt  <= '0;
      cardClk <= 1'b0;
    end
    else if (divCnt == DW'(CLK_DIV / 2 - 1))
    begin
      divCnt  <= '0;
      cardClk <= ~cardClk;
    end
    else
      divCnt <= divCnt + 1'b1;
  end

  // card reset and card bus drive
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      cardRst_n   <= 1'b0;
      cardBusOe_n <= 1'b1;
    end
    else
    begin
      cardRst_n   <= (pmState != PM_D3) && slotVccOn && !pciRstAct;
      // D2 parks the bus driven idle, D3hot lets it float
      cardBusOe_n <= !(slotVccOn && ctrl[`CTRL_BUSEN_BIT] && (pmState != PM_D3));
    end
  end

  // primary clock watch: edges found by sampling the pin
  logic [LW-1:0] lossCnt;
  logic          pclkAlive;
  logic          pclkLost;

  always_ff @(posedge clk_sys)
  begin
    if (srst || pclkEdge)
      lossCnt <= '0;
    else if (lossCnt != LW'(LOSS_CYC))
      lossCnt <= lossCnt + 1'b1;
  end

  assign pclkAlive = (lossCnt != LW'(LOSS_CYC));
  assign pclkLost  = (lossCnt == LW'(LOSS_CYC - 1));

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      pciClkStopOk <= 1'b0;
      pciBusIdle   <= 1'b0;
    end
    else
    begin
      pciClkStopOk <= (pmState == PM_D3) || (pmState == PM_D2 && !cardClkEn);
      pciBusIdle   <= isLow(pmState);
    end
  end

  // cycle claiming
  assign cycClaim = cycValid && (!isLow(pmState) || cycCfg0Self);

  // interrupt status, mask and delivery
  logic [`IRQ_W-1:0] irqSts;
  logic [`IRQ_W-1:0] irqMask;
  logic [`IRQ_W-1:0] irqSet;

  always_comb
  begin
    irqSet = '0;
    irqSet[`IRQ_REMOVE_BIT] = cardRemoved;
    irqSet[`IRQ_INSERT_BIT] = cardInserted;
    irqSet[`IRQ_CARD_BIT]   = cardIrqEdge;
    irqSet[`IRQ_STSCHG_BIT] = cardStsEdge;
    irqSet[`IRQ_PCLK_BIT]   = pclkLost;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst || leaveD3)
      irqSts <= '0;
    else if (irqStatRd)
      irqSts <= irqSet; // set wins over read clear
    else
      irqSts <= irqSts | irqSet;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst || pciRstAct || leaveD3)
      irqMask <= '0;
    else if (maskWr && ctrlOk)
      irqMask <= regWdata[`IRQ_W-1:0];
  end

  logic irqAny;
  assign irqAny = |(irqSts & irqMask);

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      irq        <= 1'b0;
      pciInt     <= 1'b0;
      pciIntOe_n <= 1'b1;
    end
    else
    begin
      // held in low states; sticky bits stay for delivery after D2, but leaving D3hot clears them
      irq        <= irqAny && !isLow(pmState);
      pciInt     <= 1'b0;
      pciIntOe_n <= !(irqAny && !isLow(pmState));
    end
  end

  // read data, one cycle after the strobe
  logic [31:0] rdMux;

  always_comb
  begin
    rdMux = '0;
    case (regAddr)
      `PM_CSR_OFS:
      begin
        rdMux[`CSR_STATE_LSB +: 2] = pmState;
        rdMux[`CSR_EN_BIT]         = pmeEn;
        rdMux[`CSR_STS_BIT]        = pmeSts;
      end
      `PM_CTRL_OFS:     rdMux[2:0] = ctrl;
      `PM_STAT_OFS:     rdMux[5:0] = {pciBusIdle, pciClkStopOk, pclkAlive,
                                      cardClkEn, slotVccOn, cardPresent};
      `PM_IRQ_STAT_OFS: rdMux[`IRQ_W-1:0] = irqSts;
      `PM_IRQ_MASK_OFS: rdMux[`IRQ_W-1:0] = irqMask;
      `PM_FUNC_OFS:     rdMux = isLow(pmState) ? 32'h0000_0000 : funcCtx;
      default:          rdMux = '0;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      regRdata <= '0;
    else
      regRdata <= regRd ? rdMux : 32'h0000_0000;
  end

endmodule : cardbus_pm_seq
`default_nettype wire

// ===== test/cb_far_model.sv
`default_nettype none
module cb_far_model
(
  // controls from the bench
  input  wire logic       pclkOn,
  input  wire logic       present,
  input  wire logic       irqReq,
  input  wire logic       chgReq,
  input  wire logic       wantClk,
  input  wire logic [1:0] cardPm,
  // pins toward the bridge
  output logic            pciClk,
  output logic            cardDetect_n,
  output logic            cardClkRun,
  output logic            cardIrq_n,
  output logic            cardStsChg_n
);
  timeunit 1ns;
  timeprecision 1ns;
  initial pciClk = 1'b0;
  // a stopped host clock freezes at its level, as a gated clock would
  always #100 pciClk = pclkOn ? ~pciClk : pciClk;
  // a card already in D3 has no function left to interrupt or ask for clock
  assign cardIrq_n    = !(irqReq && present && cardPm != 2'd3);
  assign cardClkRun   = !(wantClk && present && cardPm != 2'd3);
  assign cardStsChg_n = !(chgReq && present);
  assign cardDetect_n = !present;
endmodule : cb_far_model
`default_nettype wire

// ===== test/cb_pm_assertions.sv
`include "cb_pm_defs.svh"
`default_nettype none
module cb_pm_assertions
  import cb_pm_pkg::*;
(
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        srst,
  // register port
  input wire logic [7:0]  regAddr,
  input wire logic [31:0] regWdata,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [31:0] regRdata,
  // primary bus
  input wire logic        pciRst_n,
  input wire logic        cycValid,
  input wire logic        cycCfg0Self,
  input wire logic        cycClaim,
  input wire logic        pciClkStopOk,
  input wire logic        pciBusIdle,
  input wire logic        pciIntOe_n,
  input wire logic        pmeOe_n,
  // card side
  input wire logic        cardClkRun,
  input wire logic        cardClk,
  input wire logic        cardRst_n,
  input wire logic        cardBusOe_n,
  input wire logic        slotVccOn,
  input wire logic        irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  logic [1:0] st;
  logic       pmeEn;
  logic       lp;
  assign lp = st[1];
  // shadow state; early on host reset, which only loosens the low-power checks
  always_ff @(posedge clk_sys)
  begin
    if (srst || !pciRst_n)
      st <= PM_D0;
    else if (regWr && regAddr == `PM_CSR_OFS && (st <= regWdata[1:0] || regWdata[1:0] == 2'd0))
      st <= regWdata[1:0];
  end
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      pmeEn <= 1'b0;
    else if (regWr && regAddr == `PM_CSR_OFS)
      pmeEn <= regWdata[`CSR_EN_BIT];
  end
  sequence s_in_d3; (st == PM_D3)[*2]; endsequence
  sequence s_rd_csr; regRd && regAddr == `PM_CSR_OFS ##1 1'b1; endsequence
  property p_claim; lp |-> cycClaim == (cycValid && cycCfg0Self); endproperty
  property p_noint; lp && $past(lp) |-> !irq && pciIntOe_n; endproperty
  property p_pme; !pmeOe_n |-> $past(pmeEn); endproperty
  property p_d3; s_in_d3 |-> !cardClk && !cardRst_n && cardBusOe_n; endproperty
  property p_d2clk; (st == PM_D2 && cardClkRun)[*8] |-> !cardClk; endproperty
  property p_idle; lp && $past(lp) |-> pciBusIdle && (st != PM_D3 || pciClkStopOk); endproperty
  property p_vcc; lp && $past(lp) |-> !$rose(slotVccOn); endproperty
  property p_csr; s_rd_csr |-> regRdata[1:0] == $past(st); endproperty
  property p_rd0; !$past(regRd) |-> regRdata == 32'h0000_0000; endproperty
  a_claim: assert property (p_claim) else $error("claim outside own config cycle");
  a_noint: assert property (p_noint) else $error("interrupt in low power");
  a_pme: assert property (p_pme) else $error("event output without enable");
  a_d3: assert property (p_d3) else $error("card side not parked");
  a_d2clk: assert property (p_d2clk) else $error("card clock without request");
  a_idle: assert property (p_idle) else $error("primary side not idle");
  a_vcc: assert property (p_vcc) else $error("socket supply raised");
  a_csr: assert property (p_csr) else $error("state field wrong");
  a_rd0: assert property (p_rd0) else $error("read data outside slot");
endmodule : cb_pm_assertions
bind cardbus_pm_seq cb_pm_assertions u_chk (.*);
`default_nettype wire

// ===== test/testbench.sv
`include "cb_pm_defs.svh"
`default_nettype none
module testbench
  import cb_pm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 0, srst = 1, regWr = 0, regRd = 0, pciRst_n = 1;
  logic cycValid = 0, cycCfg0Self = 0, pclkOn = 1, present = 1;
  logic irqReq = 0, chgReq = 0, wantClk = 0;
  logic [1:0] cardPm = 2'd0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0000_0000, regRdata, d;
  logic pciClk, cycClaim, pciClkStopOk, pciBusIdle, pciInt, pciIntOe_n, pmeOut, pmeOe_n;
  logic cardDetect_n, cardClkRun, cardIrq_n, cardStsChg_n;
  logic cardClk, cardRst_n, cardBusOe_n, slotVccOn, irq;
  int errCount = 0, numChecks = 0, seed = 32'h64fc_894a, r;
  always #12.5 clk_sys = ~clk_sys;
  // host clock edges come every 8 cycles; the limit must stay well above that
  cardbus_pm_seq #(.LOSS_CYC(16)) dut (.*);
  cb_far_model far (.*);
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp)
    begin
      errCount++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task give_verdict;
    $display("checks %0d mismatches %0d", numChecks, errCount);
    if (errCount == 0 && numChecks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : give_verdict
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    regAddr <= a;
    regWdata <= v;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge clk_sys);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask : rd
  // sel 0 waits for irq, 1 for the event output
  task wait_hi(input int sel);
    for (int i = 0; i < 200; i++)
    begin
      @(posedge clk_sys);
      #1;
      if (sel == 0 ? irq === 1'b1 : pmeOe_n === 1'b0)
        return;
    end
    errCount++;
    give_verdict();
  endtask : wait_hi
  function automatic logic claim_exp(logic [1:0] s, logic v, logic c);
    return v && (s < 2'd2 || c);
  endfunction : claim_exp
  initial
  begin
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    rd(`PM_CSR_OFS);
    chk("state", d, 32'h0000_0000);
    wr(`PM_IRQ_MASK_OFS, 32'h0000_001F);
    wr(`PM_CTRL_OFS, 32'h0000_0007);
    wr(`PM_FUNC_OFS, 32'h5a5a_1234);
    rd(`PM_IRQ_STAT_OFS);
    pclkOn <= 1'b0;
    wait_hi(0);
    rd(`PM_IRQ_STAT_OFS);
    chk("clock lost", d[4], 1'b1);
    chk("vcc on", slotVccOn, 1'b1);
    pclkOn <= 1'b1;
    cardPm <= 2'd2;
    wr(`PM_CSR_OFS, 32'h0000_0002);
    irqReq <= 1'b1;
    repeat (10) @(posedge clk_sys);
    irqReq <= 1'b0;
    #1 chk("irq", irq, 1'b0);
    chk("int pin", pciIntOe_n, 1'b1);
    chk("bus idle", pciBusIdle, 1'b1);
    chk("vcc held", slotVccOn, 1'b1);
    chk("stop ok", pciClkStopOk, 1'b1);
    wr(`PM_FUNC_OFS, 32'h0000_0000);
    rd(`PM_FUNC_OFS);
    chk("func hidden", d, 32'h0000_0000);
    wantClk <= 1'b1;
    repeat (8) @(posedge clk_sys);
    rd(`PM_STAT_OFS);
    chk("clock run", d[2], 1'b1);
    chk("stop refused", pciClkStopOk, 1'b0);
    wantClk <= 1'b0;
    wr(`PM_CSR_OFS, 32'h0000_0000);
    wait_hi(0);
    rd(`PM_IRQ_STAT_OFS);
    chk("card irq kept", d[2], 1'b1);
    rd(`PM_FUNC_OFS);
    chk("func kept", d, 32'h5a5a_1234);
    for (int s = 0; s < 4; s++)
    begin
      cardPm <= s[1:0];
      wr(`PM_CSR_OFS, s);
      repeat (6)
      begin
        @(posedge clk_sys);
        r = $random(seed);
        cycValid <= r[0];
        cycCfg0Self <= r[1];
        #1 chk("claim", cycClaim, claim_exp(s[1:0], cycValid, cycCfg0Self));
      end
    end
    chk("card reset", cardRst_n, 1'b0);
    chk("card clock", cardClk, 1'b0);
    chk("card bus oe", cardBusOe_n, 1'b1);
    wr(`PM_CTRL_OFS, 32'h0000_0000);
    wr(`PM_CSR_OFS, 32'h0000_0002);
    rd(`PM_CTRL_OFS);
    chk("ctrl", d, 32'h0000_0007);
    rd(`PM_CSR_OFS);
    chk("still D3", d[1:0], 2'd3);
    chgReq <= 1'b1;
    repeat (10) @(posedge clk_sys);
    #1 chk("event off", pmeOe_n, 1'b1);
    wr(`PM_CSR_OFS, 32'h0000_0103);
    chgReq <= 1'b0;
    present <= 1'b0;
    wait_hi(1);
    chk("vcc dropped", slotVccOn, 1'b0);
    rd(`PM_CSR_OFS);
    chk("event status", d[15], 1'b1);
    wr(`PM_CSR_OFS, 32'h0000_8103);
    rd(`PM_CSR_OFS);
    chk("status cleared", d[15], 1'b0);
    #1 chk("event released", pmeOe_n, 1'b1);
    wr(`PM_CSR_OFS, 32'h0000_0000);
    present <= 1'b1;
    cardPm <= 2'd2;
    wr(`PM_CTRL_OFS, 32'h0000_0007);
    wr(`PM_CSR_OFS, 32'h0000_0002);
    pciRst_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    pciRst_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rd(`PM_CSR_OFS);
    chk("after host reset", d[1:0], 2'd0);
    rd(`PM_CTRL_OFS);
    chk("ctrl cleared", d, 32'h0000_0000);
    chk("pin data", {pciInt, pmeOut}, 2'b00);
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
